/* File: qssf_pkg.sv */
// qssf_pkg: shared types and constants for the quad supply sequencer
// assumes one 20 MHz clock domain; timers and comparators sit outside
package qssf_pkg;

   // one bit per rail, a first in the power-up order
   typedef struct packed {
      logic d;
      logic c;
      logic b;
      logic a;
   } qssf_rail_s;

   // direction-control inputs from the host or an upstream sequencer
   typedef struct packed {
      logic up_req;
      logic down_req;
      logic up_down;
   } qssf_dir_s;

   // sequencer states
   typedef enum logic [2:0] {
      QSSF_IDLE     = 3'h0,
      QSSF_UP_DELAY = 3'h1,
      QSSF_UP_BLANK = 3'h2,
      QSSF_DONE     = 3'h3,
      QSSF_DN_DELAY = 3'h4,
      QSSF_FAULT    = 3'h5
   } qssf_state_e;

   typedef logic [1:0] qssf_ch_t;

   localparam qssf_ch_t QSSF_CH_FIRST = 2'h0;
   localparam qssf_ch_t QSSF_CH_LAST = 2'h3;
   localparam qssf_ch_t QSSF_CH_STEP = 2'h1;
   localparam logic [3:0] QSSF_EN_OFF = 4'h0;
   localparam logic [3:0] QSSF_EN_ALL = 4'hf;
   localparam logic [3:0] QSSF_ONE = 4'h1;
   localparam qssf_dir_s QSSF_DIR_RST = 3'h0;

endpackage : qssf_pkg

/* File: qssf_sequencer.sv */
// qssf_sequencer: four-rail up/down supply sequencer with fault handling
// assumes all inputs are synchronous to clk_sys; the delay and blanking
// timers are external, restarted by one-cycle pulses from this block
`timescale 1ns/1ns

module qssf_sequencer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // direction control
   input wire qssf_pkg::qssf_dir_s dir_ctrl,
   // rail monitors, high when above threshold
   input wire qssf_pkg::qssf_rail_s rail_monitor,
   // external timers
   input wire logic delay_expired,
   input wire logic blank_expired,
   output logic delay_restart,
   output logic blank_restart,
   // supply enables and status
   output qssf_pkg::qssf_rail_s supply_enable,
   output logic all_rails_good,
   output logic sequence_complete_out,
   // shared open-drain fault line
   input wire logic fault_line_in,
   output logic fault_line_out,
   output logic fault_line_oe_n
);
   import qssf_pkg::*;

   qssf_state_e state;
   qssf_state_e next_state;
   qssf_ch_t ch;
   qssf_ch_t next_ch;
   qssf_dir_s dir_prev;
   logic [3:0] enable_q;
   logic [3:0] next_enable;
   logic next_sequence_complete_out;
   logic next_delay_restart;
   logic next_blank_restart;

   // edge detection on the direction inputs
   wire logic up_event;
   wire logic down_event;
   assign up_event = (dir_ctrl.up_req & ~dir_prev.up_req) | (dir_ctrl.up_down & ~dir_prev.up_down);
   assign down_event = (~dir_ctrl.down_req & dir_prev.down_req) | (~dir_ctrl.up_down & dir_prev.up_down);

   // decoding of rails, channel and timers
   wire logic [3:0] rails;
   wire logic [3:0] ch_onehot;
   wire logic rail_ok_cur;
   wire logic delay_done;
   wire logic blank_done;
   assign rails = rail_monitor;
   assign ch_onehot = QSSF_ONE << ch;
   assign rail_ok_cur = |(rails & ch_onehot);
   assign delay_done = delay_expired & ~delay_restart;
   assign blank_done = blank_expired & ~blank_restart;

   // rails that must already be good in the present state
   wire logic up_phase;
   wire logic [3:0] uv_mask;
   assign up_phase = (state == QSSF_UP_DELAY) | (state == QSSF_UP_BLANK);
   assign uv_mask = (state == QSSF_UP_BLANK) ? (enable_q & ~ch_onehot) :
                    (up_phase | (state == QSSF_DONE) | (state == QSSF_DN_DELAY)) ? enable_q : QSSF_EN_OFF;

   // fault sources
   wire logic uv_fault;
   wire logic blank_fault;
   wire logic dir_fault;
   wire logic ext_fault;
   wire logic fault_any;
   assign uv_fault = |(uv_mask & ~rails);
   assign blank_fault = (state == QSSF_UP_BLANK) & ~rail_ok_cur & blank_done;
   assign dir_fault = (up_phase & down_event) | ((state == QSSF_DN_DELAY) & up_event);
   assign ext_fault = ~fault_line_in & fault_line_oe_n;
   assign fault_any = (state != QSSF_FAULT) & (uv_fault | blank_fault | dir_fault | ext_fault);

   // next-state logic
   always_comb begin
      next_state = state;
      next_ch = ch;
      next_enable = enable_q;
      next_sequence_complete_out = sequence_complete_out;
      next_delay_restart = 1'b0;
      next_blank_restart = 1'b0;
      if (fault_any) begin
         next_state = QSSF_FAULT;
         next_enable = QSSF_EN_OFF;
         next_sequence_complete_out = 1'b0;
      end else begin
         unique case (state)
            QSSF_IDLE: begin
               if (up_event) begin
                  next_state = QSSF_UP_DELAY;
                  next_ch = QSSF_CH_FIRST;
                  next_delay_restart = 1'b1;
               end
            end
            QSSF_UP_DELAY: begin
               if (delay_done) begin
                  next_enable = enable_q | ch_onehot;
                  next_state = QSSF_UP_BLANK;
                  next_blank_restart = 1'b1;
               end
            end
            QSSF_UP_BLANK: begin
               if (rail_ok_cur) begin
                  if (ch == QSSF_CH_LAST) begin
                     next_state = QSSF_DONE;
                     next_sequence_complete_out = 1'b1;
                  end else begin
                     next_ch = ch + QSSF_CH_STEP;
                     next_state = QSSF_UP_DELAY;
                     next_delay_restart = 1'b1;
                  end
               end
            end
            QSSF_DONE: begin
               if (down_event) begin
                  next_state = QSSF_DN_DELAY;
                  next_ch = QSSF_CH_LAST;
                  next_delay_restart = 1'b1;
               end
            end
            QSSF_DN_DELAY: begin
               if (delay_done) begin
                  next_enable = enable_q & ~ch_onehot;
                  if (ch == QSSF_CH_FIRST) begin
                     next_state = QSSF_IDLE;
                     next_sequence_complete_out = 1'b0;
                  end else begin
                     next_ch = ch - QSSF_CH_STEP;
                     next_delay_restart = 1'b1;
                  end
               end
            end
            QSSF_FAULT: begin
               if (fault_line_oe_n & fault_line_in) begin
                  next_state = QSSF_IDLE;
               end
            end
            default: begin
               next_state = QSSF_FAULT;
               next_enable = QSSF_EN_OFF;
            end
         endcase
      end
   end

   // state, channel and enable registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= QSSF_IDLE;
         ch <= QSSF_CH_FIRST;
         enable_q <= QSSF_EN_OFF;
         sequence_complete_out <= 1'b0;
      end else begin
         state <= next_state;
         ch <= next_ch;
         enable_q <= next_enable;
         sequence_complete_out <= next_sequence_complete_out;
      end
   end

   // timer restarts, edge history, power good and fault line drive
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         delay_restart <= 1'b0;
         blank_restart <= 1'b0;
         dir_prev <= QSSF_DIR_RST;
         all_rails_good <= 1'b0;
         fault_line_oe_n <= 1'b1;
      end else begin
         delay_restart <= next_delay_restart;
         blank_restart <= next_blank_restart;
         dir_prev <= dir_ctrl;
         all_rails_good <= &rails;
         fault_line_oe_n <= ~(fault_any & ~ext_fault);
      end
   end

   // the shared line is only ever pulled low
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fault_line_out <= 1'b0;
      end else begin
         fault_line_out <= 1'b0;
      end
   end

   assign supply_enable = enable_q;

   // checks
   sequence s_fault_entry;
      ##1 (state == QSSF_FAULT) && (enable_q == QSSF_EN_OFF);
   endsequence

   sequence s_rise_enable;
      (enable_q & ~$past(enable_q)) != QSSF_EN_OFF;
   endsequence

   sequence s_fall_enable;
      ($past(enable_q) & ~enable_q) != QSSF_EN_OFF;
   endsequence

   AST_UP_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_IDLE) && up_event && !fault_any |=> (state == QSSF_UP_DELAY) && delay_restart)
      else $error("power-up did not start on up event");

   AST_DN_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_DONE) && down_event && !fault_any |=> (state == QSSF_DN_DELAY) && (ch == QSSF_CH_LAST))
      else $error("power-down did not start on down event");

   AST_ONE_AT_A_TIME: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state != QSSF_FAULT) ##1 (state != QSSF_FAULT) |-> $countones(enable_q ^ $past(enable_q)) <= 1)
      else $error("more than one enable changed at once");

   AST_BLANK_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_UP_BLANK) && !rail_ok_cur && !fault_any |=> (state == QSSF_UP_BLANK) && (ch == $past(ch)))
      else $error("advanced before rail reached threshold");

   AST_DELAY_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_rise_enable |-> $past(state) == QSSF_UP_DELAY && $past(delay_done))
      else $error("enable rose without sequence delay");

   AST_SEQUENCE_COMPLETE_OUT_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_UP_BLANK) && (ch == QSSF_CH_LAST) && rail_ok_cur && !fault_any
      |=> sequence_complete_out && (state == QSSF_DONE) && (enable_q == QSSF_EN_ALL))
      else $error("sequence complete not raised");

   AST_DN_REVERSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_fall_enable and (state != QSSF_FAULT) |-> ($past(state) == QSSF_DN_DELAY) && $past(delay_done)
      && (($past(enable_q) & ~enable_q) == (QSSF_ONE << $past(ch))))
      else $error("enable dropped out of order or without delay");

   AST_NO_BLANK_DOWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_DN_DELAY) |=> !blank_restart)
      else $error("blanking restarted during power-down");

   AST_DN_END: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_DN_DELAY) && (ch == QSSF_CH_FIRST) && delay_done && !fault_any
      |=> !sequence_complete_out && (enable_q == QSSF_EN_OFF) && (state == QSSF_IDLE))
      else $error("power-down end not reported");

   AST_UV_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_DONE) && (rails != QSSF_EN_ALL) |-> s_fault_entry)
      else $error("undervoltage in powered-on state missed");

   AST_FAULT_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fault_any |-> s_fault_entry)
      else $error("fault did not switch all enables off");

   // fault handling ends one cycle after the shared line is seen released
   AST_FAULT_EXIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_FAULT) && fault_line_oe_n && fault_line_in |=> (state == QSSF_IDLE))
      else $error("fault handling did not return to idle");

   // nothing stays enabled or reported complete while faulted
   AST_FAULT_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_FAULT) |-> (enable_q == QSSF_EN_OFF) && !sequence_complete_out)
      else $error("enable or complete high in fault state");

   AST_FAULT_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fault_any && !ext_fault |=> !fault_line_oe_n ##1 fault_line_oe_n)
      else $error("fault line not pulsed low on own fault");

   AST_EXT_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state != QSSF_FAULT) && fault_line_oe_n && !fault_line_in |-> s_fault_entry)
      else $error("external fault ignored");

   AST_PG: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 all_rails_good == $past(&rails))
      else $error("power good does not follow monitors");

   AST_BLANK_TIMEOUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_UP_BLANK) && !rail_ok_cur && blank_done |-> s_fault_entry)
      else $error("blanking timeout not treated as fault");

   // a direction edge against the running sequence is a fault in either direction
   AST_DIR_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (up_phase && down_event) || ((state == QSSF_DN_DELAY) && up_event) |-> s_fault_entry)
      else $error("unexpected direction edge not treated as fault");

   // each new sequence delay starts with a fresh timer restart
   AST_DELAY_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == QSSF_UP_BLANK) && rail_ok_cur && (ch != QSSF_CH_LAST) && !fault_any
      |=> delay_restart && (state == QSSF_UP_DELAY))
      else $error("delay timer not restarted for next rail");

endmodule : qssf_sequencer

/* File: qssf_rail_model.sv */
// qssf_rail_model: four supply regulators plus the delay and blanking timers
// assumes enables and restart pulses change just after clk_sys rising edges
`timescale 1ns/1ns

module qssf_rail_model #(
   parameter int DLY = 4,
   parameter int BLK = 10
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // from the sequencer
   input wire qssf_pkg::qssf_rail_s supply_enable,
   input wire logic delay_restart,
   input wire logic blank_restart,
   // scenario controls: ramp length and rails that never come up
   input wire logic [7:0] rise_cycles,
   input wire logic [3:0] dead,
   // to the sequencer
   output qssf_pkg::qssf_rail_s rail_monitor,
   output logic delay_expired,
   output logic blank_expired
);
   import qssf_pkg::*;
   int dcnt;
   int bcnt;
   int rcnt [4];
   logic [3:0] en;
   logic [3:0] mon;
   assign en = supply_enable;
   assign rail_monitor = mon;
   // timers restart on each pulse and report expiry as a level
   assign delay_expired = (dcnt >= DLY);
   assign blank_expired = (bcnt >= BLK);
   // a rail ramps rise_cycles+1 cycles after its enable, drops at once when off or dead
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dcnt <= 0;
         bcnt <= 0;
         mon <= 4'h0;
         for (int i = 0; i < 4; i++) rcnt[i] <= 0;
      end else begin
         dcnt <= delay_restart ? 0 : dcnt + 1;
         bcnt <= blank_restart ? 0 : bcnt + 1;
         for (int i = 0; i < 4; i++) begin
            rcnt[i] <= (en[i] && !dead[i]) ? rcnt[i] + 1 : 0;
            mon[i] <= en[i] && !dead[i] && (rcnt[i] >= rise_cycles);
         end
      end
   end
endmodule : qssf_rail_model

/* File: tb.sv */
// tb: self-checking bench for the quad supply sequencer
// assumes the rail model above; inputs change on falling clock edges
`timescale 1ns/1ns

module tb;
   import qssf_pkg::*;
   localparam int DLY = 4;
   localparam int BLK = 10;
   logic clk_sys;
   logic rst_n;
   qssf_dir_s dir_ctrl;
   qssf_rail_s rail_monitor;
   qssf_rail_s supply_enable;
   logic delay_expired, blank_expired, delay_restart, blank_restart;
   logic all_rails_good, sequence_complete_out;
   logic fault_line_in, fault_line_out, fault_line_oe_n;
   logic ext_pull;
   logic [7:0] rise_cycles;
   logic [3:0] dead;
   int bad_count;
   int n_checks;
   int pulls;
   int pull_base;

   // shared fault wire: pulled up, low when either party pulls
   assign fault_line_in = (fault_line_oe_n ? 1'b1 : fault_line_out) & !ext_pull;

   qssf_sequencer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .dir_ctrl(dir_ctrl),
      .rail_monitor(rail_monitor), .delay_expired(delay_expired),
      .blank_expired(blank_expired), .delay_restart(delay_restart),
      .blank_restart(blank_restart), .supply_enable(supply_enable),
      .all_rails_good(all_rails_good), .sequence_complete_out(sequence_complete_out),
      .fault_line_in(fault_line_in), .fault_line_out(fault_line_out),
      .fault_line_oe_n(fault_line_oe_n));

   qssf_rail_model #(.DLY(DLY), .BLK(BLK)) u_rails (.clk_sys(clk_sys), .rst_n(rst_n),
      .supply_enable(supply_enable), .delay_restart(delay_restart),
      .blank_restart(blank_restart), .rise_cycles(rise_cycles), .dead(dead),
      .rail_monitor(rail_monitor), .delay_expired(delay_expired),
      .blank_expired(blank_expired));

   // 20 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // cycles in which this block pulls the shared line
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) pulls <= 0;
      else if (fault_line_oe_n === 1'b0) pulls <= pulls + 1;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic ok, input string what);
      n_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask : check

   // wait for the next enable change, then judge its value and spacing
   task automatic wait_en(input logic [3:0] exp, input int min_gap, input string what);
      logic [3:0] prev;
      int n;
      prev = supply_enable;
      n = 0;
      while (supply_enable === prev && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 200) begin
         bad_count++;
         $display("[ERR] %0t no enable change: %s", $time, what);
         report_and_stop();
      end else check(supply_enable === exp && n >= min_gap, what);
   endtask : wait_en

   task automatic start_seq(input int mode);
      if (mode == 0) begin
         dir_ctrl.up_req = 1'b0;
         @(negedge clk_sys);
         dir_ctrl.up_req = 1'b1;
      end else dir_ctrl.up_down = 1'b1;
   endtask : start_seq

   task automatic power_up(input int mode);
      start_seq(mode);
      wait_en(4'h1, DLY, "rail a first");
      wait_en(4'h3, DLY, "rail b after a good");
      wait_en(4'h7, DLY, "rail c after delay");
      wait_en(4'hf, DLY, "rail d last");
      repeat (12) @(negedge clk_sys);
      check(sequence_complete_out === 1'b1, "complete after power-up");
      check(all_rails_good === 1'b1, "all good when powered");
   endtask : power_up

   task automatic settle();
      repeat (4) @(negedge clk_sys);
      dir_ctrl.down_req = 1'b1;
      dead = 4'h0;
      repeat (2) @(negedge clk_sys);
      pull_base = pulls;
   endtask : settle

   task automatic full_cycle(input int mode);
      power_up(mode);
      if (mode == 0) dir_ctrl.down_req = 1'b0;
      else dir_ctrl.up_down = 1'b0;
      wait_en(4'h7, DLY, "rail d off first");
      wait_en(4'h3, DLY, "rail c off after delay");
      wait_en(4'h1, DLY, "rail b off");
      wait_en(4'h0, DLY, "rail a off last");
      repeat (3) @(negedge clk_sys);
      check(sequence_complete_out === 1'b0, "complete low after power-down");
      check(pulls - pull_base == 0, "no fault while rails switch off");
      settle();
   endtask : full_cycle

   task automatic blank_fault();
      dead = 4'h2;
      start_seq(0);
      wait_en(4'h1, DLY, "rail a up");
      wait_en(4'h3, DLY, "rail b enabled");
      wait_en(4'h0, BLK, "all off on blanking expiry");
      @(negedge clk_sys);
      check(pulls - pull_base == 1, "one-cycle pull on own fault");
      settle();
   endtask : blank_fault

   task automatic drop_fault();
      power_up(0);
      dead = 4'h4;
      wait_en(4'h0, 0, "all off when rail c drops");
      check(fault_line_oe_n === 1'b0 && fault_line_out === 1'b0, "own fault drives line low");
      check(all_rails_good === 1'b0, "good low on a low rail");
      check(sequence_complete_out === 1'b0, "complete low on fault");
      @(negedge clk_sys);
      check(pulls - pull_base == 1, "own fault pulls line");
      settle();
   endtask : drop_fault

   task automatic wrong_dir();
      start_seq(0);
      wait_en(4'h1, DLY, "rail a up");
      dir_ctrl.down_req = 1'b0;
      wait_en(4'h0, 0, "down edge in power-up is a fault");
      @(negedge clk_sys);
      check(pulls - pull_base == 1, "unexpected input pulls line");
      settle();
   endtask : wrong_dir

   // an up edge while rails are switching off is an unexpected input
   task automatic wrong_dir_down();
      power_up(0);
      dir_ctrl.down_req = 1'b0;
      wait_en(4'h7, DLY, "rail d off before the stray edge");
      dir_ctrl.up_req = 1'b0;
      @(negedge clk_sys);
      dir_ctrl.up_req = 1'b1;
      wait_en(4'h0, 0, "up edge in power-down is a fault");
      @(negedge clk_sys);
      check(pulls - pull_base == 1, "stray up edge pulls line");
      settle();
   endtask : wrong_dir_down

   task automatic ext_fault();
      power_up(1);
      ext_pull = 1'b1;
      wait_en(4'h0, 0, "all off on external fault");
      repeat (5) @(negedge clk_sys);
      check(supply_enable === 4'h0 && pulls - pull_base == 0, "held off, no own pull");
      ext_pull = 1'b0;
      dir_ctrl.up_down = 1'b0;
      settle();
   endtask : ext_fault

   initial begin
      rst_n = 1'b0;
      dir_ctrl = '{up_req: 1'b0, down_req: 1'b1, up_down: 1'b0};
      ext_pull = 1'b0;
      rise_cycles = 8'h02;
      dead = 4'h0;
      bad_count = 0;
      n_checks = 0;
      pull_base = 0;
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      settle();
      full_cycle(0);
      rise_cycles = 8'h06;
      full_cycle(1);
      rise_cycles = 8'h02;
      blank_fault();
      drop_fault();
      wrong_dir();
      wrong_dir_down();
      ext_fault();
      full_cycle(0);
      report_and_stop();
   end
endmodule : tb
